/* File: rtl/sssw_pkg.sv */
// Purpose: constants shared by the supply supervisor serial word logic
// Assumes: core clock of 25 MHz
// Notes:   bit positions refer to the 16-bit control and diagnosis words and the 17-bit synchronised pin vector
package sssw_pkg;
	localparam int WORD_W = 16;
	localparam int CNT_W  = 5;
	localparam int NTRK   = 6;
	localparam int SETTLE_W = 16;
	// ------------------------------------------------------------
	// Control word fields
	// ------------------------------------------------------------
	localparam int C_DIS_A   = 0;
	localparam int C_TRK_LO  = 2;
	localparam int C_DIS_B   = 9;
	localparam int C_RST_A   = 10;
	localparam int C_RST_B   = 11;
	localparam int C_WIN_LO  = 12;
	localparam int C_WIN_HI  = 13;
	localparam int C_DIS_C   = 14;
	localparam int C_KICK    = 15;
	localparam logic [15:0] CTRL_RESET = 16'h4DFD;
	// ------------------------------------------------------------
	// Diagnosis word fields
	// ------------------------------------------------------------
	localparam int S_ERR     = 0;
	localparam int S_TEMP    = 1;
	localparam int S_TRK_LO  = 2;
	localparam int S_WARM1   = 8;
	localparam int S_WARM2   = 9;
	localparam int S_PHASE   = 10;
	localparam int S_RAIL_LO = 11;
	localparam int S_DOG     = 14;
	localparam int S_BUCK    = 15;
	// ------------------------------------------------------------
	// Synchronised pin vector layout
	// ------------------------------------------------------------
	localparam int P_CS = 0;
	localparam int P_SCLK = 1;
	localparam int P_MOSI = 2;
	localparam int P_TEMP = 3;
	localparam int P_TRK_LO = 4;
	localparam int P_RAIL_LO = 10;
	localparam int P_BUCK = 13;
	localparam int P_WARM1 = 14;
	localparam int P_WARM2 = 15;
	localparam int P_COLD = 16;
	localparam int PIN_W = 17;
	localparam logic [16:0] PIN_RESET = 17'h023F1;
	// ------------------------------------------------------------
	// Times
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 25;
	localparam int SETTLE_TIME_US = 1000;
	localparam int SETTLE_CYCLES_DEF = SETTLE_TIME_US * CLK_MHZ;
	localparam logic [6:0] HOLD_MS_00 = 7'd64;
	localparam logic [6:0] HOLD_MS_10 = 7'd32;
	localparam logic [6:0] HOLD_MS_01 = 7'd16;
	localparam logic [6:0] HOLD_MS_11 = 7'd8;
	localparam logic [7:0] WIN_MS_00 = 8'd128;
	localparam logic [7:0] WIN_MS_10 = 8'd64;
	localparam logic [7:0] WIN_MS_01 = 8'd32;
	localparam logic [7:0] WIN_MS_11 = 8'd16;
endpackage

/* File: rtl/sssw_words.sv */
// Purpose: serial control and diagnosis words of a multi-rail supply supervisor
// Assumes: host clock well below core_clk/4; sclk idles low, data taken on rising sclk
// Notes:   all pins but windowPhase and dogFault sampled through two flip-flops; watchdog counters live outside
// Overview of operation
// - Bits 10 and 11 pick the reset hold time 64/32/16/8 ms, default 11, kept over warm start.
// - Bits 12 and 13 pick open and closed window length 128/64/32/16 ms, default 00.
// - The watchdog runs only when bits 0, 9, 14 read 0, 1, 0; default 101 keeps it off.
// - Bit 15 of a written word is the watchdog trigger, default 0.
// - Diagnosis bit 0 is a latched summary error flag resetting to 0.
// - Diagnosis bit 1 shows the overtemperature prewarning live, default 0.
// - Diagnosis bits 2 to 7 show tracker settled status live, default 1.
// - Diagnosis bits 8 and 9 are latched warm start flags of rails 1 and 2, default 1.
// - Diagnosis bit 10 shows the watchdog phase live, 1 in the closed window.
// - Diagnosis bits 11 to 13 show rail reset conditions live, default 0.
// - Bit 14 is a latched watchdog fault, default 0, and bit 15 shows the buck converter live, default 1.
// - Error pin low and summary bit set on prewarning, watchdog fault, cold start or a tracker not settled in 1 ms.
// - Both start flags clear after every completed transfer.
// - A trigger is recognised at chip select rising of a full word when bit 15 was 1 and bits 0, 9, 14 of that word read 0, 1, 0.
// - Words shift LSB first while select is low, status out at once, new word taken and data out released at select rising.
// - The error pin is active low.
`timescale 1ns/1ps
`default_nettype none
module sssw_words
	import sssw_pkg::*;
#(
	parameter int SETTLE_CYCLES = sssw_pkg::SETTLE_CYCLES_DEF
) (
	// Clock and reset
	input  wire logic                          core_clk,
	input  wire logic                          rst_n,
	// Serial pins
	input  wire logic                          csN,
	input  wire logic                          sclk,
	input  wire logic                          mosi,
	output logic                               misoOut,
	output logic                               misoOe,
	// Analog status inputs
	input  wire logic                          tempWarn,
	input  wire logic [sssw_pkg::NTRK-1:0]     followerSettled,
	input  wire logic [2:0]                    railResetActive,
	input  wire logic                          buckOn,
	input  wire logic                          warmStart1,
	input  wire logic                          warmStart2,
	input  wire logic                          rail1Cold,
	// Watchdog engine, same clock
	input  wire logic                          windowPhase,
	input  wire logic                          dogFault,
	// Control outputs
	output logic [sssw_pkg::WORD_W-1:0]        controlWord,
	output logic [6:0]                         resetHoldMs,
	output logic [7:0]                         windowMs,
	output logic                               dogEnable,
	output logic                               dogKick,
	output logic                               errN
);
	import sssw_pkg::*;

	// Elaboration-time refusal of a settle count the counter cannot hold
	if (SETTLE_CYCLES < 1 || SETTLE_CYCLES >= (1 << SETTLE_W)) begin
		$error("SETTLE_CYCLES out of range");
	end

	localparam logic [SETTLE_W-1:0] SETTLE_LIM = SETTLE_W'(SETTLE_CYCLES - 1);
	localparam logic [CNT_W-1:0]    FULL_CNT   = CNT_W'(WORD_W);

	typedef struct packed {
		logic [PIN_W-1:0]                meta;
		logic [PIN_W-1:0]                pins;
		logic                            sclkPrev;
		logic                            csPrev;
		logic [WORD_W-1:0]               rx;
		logic [WORD_W-1:0]               tx;
		logic [WORD_W-1:0]               snap;
		logic [CNT_W-1:0]                bitCnt;
		logic [WORD_W-1:0]               ctrl;
		logic                            errLat;
		logic                            warm1Lat;
		logic                            warm2Lat;
		logic                            dogLat;
		logic [NTRK-1:0][SETTLE_W-1:0]   settleCnt;
		logic [NTRK-1:0]                 trkFail;
		logic                            miso;
		logic                            misoEn;
		logic [6:0]                      holdMs;
		logic [7:0]                      winMs;
		logic                            dogEn;
		logic                            kick;
		logic                            errOutN;
	} sssw_state_s;

	sssw_state_s st_q;
	sssw_state_s st_d;

	// ------------------------------------------------------------
	// Field decoders
	// ------------------------------------------------------------
	function automatic logic [6:0] holdDecode(input logic [WORD_W-1:0] w);
		case ({w[C_RST_A], w[C_RST_B]})
			2'b00: holdDecode = HOLD_MS_00;
			2'b10: holdDecode = HOLD_MS_10;
			2'b01: holdDecode = HOLD_MS_01;
			default: holdDecode = HOLD_MS_11;
		endcase
	endfunction

	function automatic logic [7:0] winDecode(input logic [WORD_W-1:0] w);
		case ({w[C_WIN_LO], w[C_WIN_HI]})
			2'b00: winDecode = WIN_MS_00;
			2'b10: winDecode = WIN_MS_10;
			2'b01: winDecode = WIN_MS_01;
			default: winDecode = WIN_MS_11;
		endcase
	endfunction

	function automatic logic enDecode(input logic [WORD_W-1:0] w);
		enDecode = !w[C_DIS_A] && w[C_DIS_B] && !w[C_DIS_C];
	endfunction

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic              csFall;
		logic              csRise;
		logic              sclkRise;
		logic              sclkFall;
		logic              done;
		logic              errCause;
		logic [WORD_W-1:0] status;
		logic [WORD_W-1:0] newCtrl;
		csFall   = 1'b0;
		csRise   = 1'b0;
		sclkRise = 1'b0;
		sclkFall = 1'b0;
		done     = 1'b0;
		errCause = 1'b0;
		status   = '0;
		newCtrl  = '0;
		st_d = st_q;
		st_d.meta = {rail1Cold, warmStart2, warmStart1, buckOn, railResetActive,
			followerSettled, tempWarn, mosi, sclk, csN};
		st_d.pins = st_q.meta;
		st_d.sclkPrev = st_q.pins[P_SCLK];
		st_d.csPrev = st_q.pins[P_CS];
		csFall   = st_q.csPrev && !st_q.pins[P_CS];
		csRise   = !st_q.csPrev && st_q.pins[P_CS];
		sclkRise = !st_q.pins[P_CS] && !st_q.sclkPrev && st_q.pins[P_SCLK];
		sclkFall = !st_q.pins[P_CS] && st_q.sclkPrev && !st_q.pins[P_SCLK];
		done     = csRise && (st_q.bitCnt == FULL_CNT);

		// Tracker settle supervision: only switched-on trackers are timed
		for (int i = 0; i < NTRK; i++) begin
			if (!st_q.ctrl[C_TRK_LO + i] || st_q.pins[P_TRK_LO + i]) begin
				st_d.settleCnt[i] = '0;
				st_d.trkFail[i] = 1'b0;
			end else if (st_q.settleCnt[i] == SETTLE_LIM) begin
				st_d.trkFail[i] = 1'b1;
			end else begin
				st_d.settleCnt[i] = st_q.settleCnt[i] + 1'b1;
			end
		end

		// Fault latch first, so the summary can clear in the same commit as the fault
		st_d.dogLat = (st_q.dogLat && !(done && st_q.snap[S_DOG])) || dogFault;
		errCause = st_q.pins[P_TEMP] || st_d.dogLat
			|| !st_q.warm1Lat || !st_q.warm2Lat || (|st_q.trkFail);

		status[S_ERR]  = st_q.errLat;
		status[S_TEMP] = st_q.pins[P_TEMP];
		status[S_TRK_LO +: NTRK] = st_q.pins[P_TRK_LO +: NTRK];
		status[S_WARM1] = st_q.warm1Lat;
		status[S_WARM2] = st_q.warm2Lat;
		status[S_PHASE] = windowPhase;
		status[S_RAIL_LO +: 3] = st_q.pins[P_RAIL_LO +: 3];
		status[S_DOG]  = st_q.dogLat;
		status[S_BUCK] = st_q.pins[P_BUCK];

		// Latched flags: a pending cause always wins over a clear
		st_d.errLat = (st_q.errLat && !(done && st_q.snap[S_ERR])) || errCause;
		st_d.warm1Lat = (st_q.warm1Lat && !done) || st_q.pins[P_WARM1];
		st_d.warm2Lat = (st_q.warm2Lat && !done) || st_q.pins[P_WARM2];
		st_d.errOutN = !st_d.errLat;

		// ------------------------------------------------------------
		// Shifter
		// ------------------------------------------------------------
		st_d.kick = 1'b0;
		if (csFall) begin
			st_d.snap   = status;
			st_d.tx     = status;
			st_d.miso   = status[0];
			st_d.misoEn = 1'b1;
			st_d.bitCnt = '0;
		end else if (sclkRise) begin
			st_d.rx = {st_q.pins[P_MOSI], st_q.rx[WORD_W-1:1]};
			if (st_q.bitCnt != FULL_CNT)
				st_d.bitCnt = st_q.bitCnt + 1'b1;
		end else if (sclkFall) begin
			// Daisy chain: the word shifted in reappears after our own status
			st_d.tx   = {st_q.pins[P_MOSI], st_q.tx[WORD_W-1:1]};
			st_d.miso = st_q.tx[1];
		end
		if (csRise) begin
			st_d.misoEn = 1'b0;
			st_d.miso   = 1'b0;
		end
		newCtrl = st_q.ctrl;
		if (done) begin
			newCtrl = st_q.rx;
			st_d.kick = st_q.rx[C_KICK] && enDecode(st_q.rx);
		end
		// A cold first rail restores defaults; otherwise the settings survive
		if (st_q.pins[P_COLD])
			newCtrl = CTRL_RESET;
		st_d.ctrl   = newCtrl;
		st_d.holdMs = holdDecode(newCtrl);
		st_d.winMs  = winDecode(newCtrl);
		st_d.dogEn  = enDecode(newCtrl);
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			st_q <= '0;
			st_q.meta <= PIN_RESET;
			st_q.pins <= PIN_RESET;
			st_q.sclkPrev <= 1'b0;
			st_q.csPrev <= 1'b1;
			st_q.ctrl <= CTRL_RESET;
			st_q.holdMs <= HOLD_MS_11;
			st_q.winMs <= WIN_MS_00;
			st_q.warm1Lat <= 1'b1;
			st_q.warm2Lat <= 1'b1;
			st_q.errOutN <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	assign misoOut     = st_q.miso;
	assign misoOe      = st_q.misoEn;
	assign controlWord = st_q.ctrl;
	assign resetHoldMs = st_q.holdMs;
	assign windowMs    = st_q.winMs;
	assign dogEnable   = st_q.dogEn;
	assign dogKick     = st_q.kick;
	assign errN        = st_q.errOutN;
endmodule
`default_nettype wire

/* File: tb/sssw_words_chk.sv */
// Purpose: port assertions for the serial word block
// Assumes: one core_clk domain, synchronous active-low reset
// Notes:   delays allow two sync stages plus one output register
`timescale 1ns/1ps
`default_nettype none
module sssw_words_chk (
	// Clock and reset
	input wire logic        core_clk,
	input wire logic        rst_n,
	// Observed ports
	input wire logic        csN,
	input wire logic        tempWarn,
	input wire logic        dogFault,
	input wire logic        rail1Cold,
	input wire logic        misoOe,
	input wire logic [15:0] controlWord,
	input wire logic [6:0]  resetHoldMs,
	input wire logic [7:0]  windowMs,
	input wire logic        dogEnable,
	input wire logic        dogKick,
	input wire logic        errN
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence s_idle; csN [*6]; endsequence
	sequence s_busy; !csN [*6]; endsequence
	idle_oe_a: assert property (s_idle |-> !misoOe)
		else $error("data out driven while idle");
	busy_oe_a: assert property (s_busy |-> misoOe)
		else $error("data out released in frame");
	hold_map_a: assert property (resetHoldMs == (controlWord[11] ? (controlWord[10] ? 7'd8 :
		7'd16) : (controlWord[10] ? 7'd32 : 7'd64))) else $error("hold time mismatch");
	win_map_a: assert property (windowMs == (controlWord[13] ? (controlWord[12] ? 8'd16 :
		8'd32) : (controlWord[12] ? 8'd64 : 8'd128))) else $error("window length mismatch");
	dog_en_a: assert property (dogEnable == (!controlWord[0] && controlWord[9] && !controlWord[14]))
		else $error("enable code mismatch");
	kick_src_a: assert property (dogKick |-> dogEnable && controlWord[15] && csN)
		else $error("kick without trigger");
	kick_once_a: assert property (dogKick |=> !dogKick)
		else $error("kick longer than a cycle");
	temp_err_a: assert property (tempWarn [*6] |-> !errN)
		else $error("prewarning without error pin");
	fault_err_a: assert property (dogFault |-> ##[1:3] !errN)
		else $error("fault without error pin");
	word_keep_a: assert property ((csN && !rail1Cold) [*8] |=> $stable(controlWord))
		else $error("control word changed while idle");
	cold_load_a: assert property (rail1Cold [*4] |-> controlWord == 16'h4DFD)
		else $error("cold start kept old settings");
endmodule
bind sssw_words sssw_words_chk i_chk (.core_clk(core_clk), .rst_n(rst_n), .csN(csN),
	.tempWarn(tempWarn), .dogFault(dogFault), .rail1Cold(rail1Cold), .misoOe(misoOe),
	.controlWord(controlWord), .resetHoldMs(resetHoldMs), .windowMs(windowMs),
	.dogEnable(dogEnable), .dogKick(dogKick), .errN(errN));
`default_nettype wire

/* File: tb/sssw_host.sv */
// Purpose: serial master model for the supervisor link
// Assumes: sclk idles low, 320 ns period, data read just before sclk falls
// Notes:   mosi shows the inverse of its last bit outside frames
`timescale 1ns/1ps
`default_nettype none
module sssw_host (
	// Link
	input  wire logic core_clk,
	input  wire logic misoOut,
	output logic      csN,
	output logic      sclk,
	output logic      mosi
);
	initial begin
		csN = 1'b1;
		sclk = 1'b0;
		mosi = 1'b0;
	end
	// Fewer than 16 bits makes an aborted frame
	task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
		r = 16'h0000;
		@(negedge core_clk) csN <= 1'b0;
		repeat (8) @(negedge core_clk);
		for (int i = 0; i < n; i++) begin
			mosi <= w[i];
			repeat (4) @(negedge core_clk);
			sclk <= 1'b1;
			repeat (4) @(negedge core_clk);
			r[i] = misoOut;
			sclk <= 1'b0;
		end
		repeat (8) @(negedge core_clk);
		csN <= 1'b1;
		mosi <= ~mosi;
		repeat (8) @(negedge core_clk);
	endtask
endmodule
`default_nettype wire

/* File: tb/test_supply_supervisor_spi_words.sv */
// Purpose: self-checking bench for the serial word block
// Assumes: settle count shortened to 20 cycles
// Notes:   rail reset, buck and rail 1 warm start inputs are held constant
`timescale 1ns/1ps
`default_nettype none
module test_supply_supervisor_spi_words;
	import sssw_pkg::*;
	localparam logic [15:0] CW = 16'h03FC;
	localparam logic [15:0] ST = 16'hAFFC;
	localparam logic [7:0] HOLD_T [4] = '{8'd64, 8'd32, 8'd16, 8'd8};
	localparam logic [7:0] WIN_T [4] = '{8'd128, 8'd64, 8'd32, 8'd16};
	logic        core_clk, rst_n, tempWarn, warm2, dogFault, misoOut, misoOe;
	logic        csN, sclk, mosi, dogEnable, dogKick, errN, phase, cold;
	logic [5:0]  settled;
	logic [15:0] controlWord, w, r;
	logic [6:0]  resetHoldMs;
	logic [7:0]  windowMs;
	int          num_errors, n_checks, kicks, k;
	sssw_words #(.SETTLE_CYCLES(20)) i_dut (.core_clk(core_clk), .rst_n(rst_n), .csN(csN),
		.sclk(sclk), .mosi(mosi), .misoOut(misoOut), .misoOe(misoOe), .tempWarn(tempWarn),
		.followerSettled(settled), .railResetActive(3'b101), .buckOn(1'b1), .warmStart1(1'b1),
		.warmStart2(warm2), .rail1Cold(cold), .windowPhase(phase), .dogFault(dogFault),
		.controlWord(controlWord), .resetHoldMs(resetHoldMs), .windowMs(windowMs),
		.dogEnable(dogEnable), .dogKick(dogKick), .errN(errN));
	sssw_host i_host (.core_clk(core_clk), .misoOut(misoOut), .csN(csN), .sclk(sclk), .mosi(mosi));
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	always @(posedge core_clk) if (dogKick === 1'b1) kicks++;
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		n_checks++;
		if (s !== e) begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic rd(input logic [15:0] e);
		i_host.xfer(CW, 16, r);
		chk(r, e);
	endtask
	task automatic conclude;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		#2_000_000;
		num_errors++;
		conclude();
	end
	initial begin
		rst_n = 1'b0;
		tempWarn = 1'b0;
		warm2 = 1'b1;
		dogFault = 1'b0;
		settled = 6'h3F;
		phase = 1'b1;
		cold = 1'b0;
		repeat (12) @(negedge core_clk);
		rst_n = 1'b1;
		repeat (4) @(negedge core_clk);
		chk(controlWord, CTRL_RESET);
		chk({9'h000, resetHoldMs}, 16'h0008);
		chk({8'h00, windowMs}, 16'h0080);
		chk({15'h0000, errN}, 16'h0001);
		rd(ST);
		$display("test reset done");
		for (int j = 0; j < 8; j++) begin
			w = CW | 16'h8000 | (16'(j & 3) << 10) | (16'(j & 3) << 12);
			w[0] = j[2];
			w[9] = j[1];
			w[14] = j[0];
			k = kicks;
			i_host.xfer(w, 16, r);
			chk(controlWord, w);
			chk({9'h000, resetHoldMs}, {8'h00, HOLD_T[j & 3]});
			chk({8'h00, windowMs}, {8'h00, WIN_T[j & 3]});
			chk({15'h0000, dogEnable}, 16'(j == 2));
			chk(16'(kicks - k), 16'(j == 2));
		end
		i_host.xfer(16'h0000, 15, r);
		chk(controlWord, w);
		k = kicks;
		rd(ST);
		chk(16'(kicks - k), 16'h0000);
		$display("test control word done");
		tempWarn = 1'b1;
		repeat (8) @(negedge core_clk);
		chk({15'h0000, errN}, 16'h0000);
		rd(ST | 16'h0003);
		tempWarn = 1'b0;
		rd(ST | 16'h0001);
		rd(ST);
		chk({15'h0000, errN}, 16'h0001);
		@(negedge core_clk) dogFault = 1'b1;
		@(negedge core_clk) dogFault = 1'b0;
		rd(ST | 16'h4001);
		rd(ST);
		$display("test error latch done");
		warm2 = 1'b0;
		rd(ST);
		rd(16'hADFD);
		warm2 = 1'b1;
		rd(16'hAFFD);
		rd(ST);
		settled = 6'h3E;
		repeat (40) @(negedge core_clk);
		chk({15'h0000, errN}, 16'h0000);
		rd(16'hAFF9);
		settled = 6'h3F;
		rd(16'hAFFD);
		rd(ST);
		$display("test start and tracker done");
		phase = 1'b0;
		rd(16'hABFC);
		phase = 1'b1;
		cold = 1'b1;
		repeat (8) @(negedge core_clk);
		chk(controlWord, CTRL_RESET);
		chk({9'h000, resetHoldMs}, 16'h0008);
		chk({8'h00, windowMs}, 16'h0080);
		chk({15'h0000, dogEnable}, 16'h0000);
		cold = 1'b0;
		repeat (8) @(negedge core_clk);
		chk(controlWord, CTRL_RESET);
		$display("test phase and cold start done");
		conclude();
	end
endmodule
`default_nettype wire
